//--- common/bbl_consts.svh
// Opcode fields, flag positions and reset values for the instruction decoder.
`ifndef BBL_CONSTS_SVH
`define BBL_CONSTS_SVH

`define BBL_OP_ADD_CARRY 6'h3d
`define BBL_OP_SUB_BORROW 6'h3b
`define BBL_OP_ROT_LEFT 6'h0d
`define BBL_OP_ROT_RIGHT 6'h0c
`define BBL_OP_XOR_WF 6'h06
`define BBL_OP_OR_WF 6'h04
`define BBL_OP_DEC_SKIP 6'h0b
`define BBL_OP_INC_SKIP 6'h0f
`define BBL_OP_OR_LIT 6'h38
`define BBL_OP_XOR_LIT 6'h3a
`define BBL_OP_LIT_MINUS_W 6'h3c
`define BBL_OP_LOAD_PCH 6'h31
`define BBL_BIT_SKIP_CLEAR 4'h6
`define BBL_BIT_SKIP_SET 4'h7

`define BBL_FLAG_C 0
`define BBL_FLAG_DC 1
`define BBL_FLAG_Z 2

`define BBL_DEST_BIT 7
`define BBL_ADDR_MSB 6
`define BBL_INDIRECT0_ADDR 7'h00
`define BBL_INDIRECT1_ADDR 7'h01
`define BBL_STATUS_RESET 3'h0
`define BBL_WREG_RESET 8'h00
`define BBL_PCH_RESET 7'h00

`endif

//--- common/bbl_pkg.sv
// Types shared by the instruction decoder and its helpers.
package bbl_pkg;
    typedef enum logic [1:0] {
        BBL_EXEC,
        BBL_EXTRA,
        BBL_NOP
    } bbl_phase_e;

    typedef struct packed {
        logic [7:0] result;
        logic carry;
        logic digit_carry;
        logic zero;
    } bbl_alu_s;

    typedef struct packed {
        logic valid;
        logic [13:0] word;
    } bbl_fetch_s;

    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } bbl_file_wr_s;
endpackage

//--- rtl/bbl_alu.sv
// Eight-bit adder with carry and digit carry used for add and subtract forms.
`timescale 1ns/1ps
`default_nettype none
module bbl_alu (
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic carry_in,
    output bbl_pkg::bbl_alu_s sum_out
);
    logic [4:0] low;
    logic [8:0] full;

    // Subtraction is done by the caller as a plus inverted b plus carry.
    always_comb begin
        low = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]} + {4'h0, carry_in};
        full = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in};
        sum_out.result = full[7:0];
        sum_out.carry = full[8];
        sum_out.digit_carry = low[4];
        sum_out.zero = (full[7:0] == 8'h00);
    end
endmodule
`default_nettype wire

//--- rtl/bbl_decoder.sv
// Decode and execute stage for byte, skip and literal instructions.
`timescale 1ns/1ps
`default_nettype none
`include "bbl_consts.svh"
module bbl_decoder (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire bbl_pkg::bbl_fetch_s fetch_in,
    input wire logic [7:0] file_rd_data_in,
    input wire logic [7:0] pointer0_high_in,
    input wire logic [7:0] pointer1_high_in,
    output logic fetch_ready_out,
    output logic [6:0] file_rd_addr_out,
    output bbl_pkg::bbl_file_wr_s file_wr_out,
    output logic [7:0] wreg_out,
    output logic [2:0] status_out,
    output logic [6:0] pc_high_latch_out,
    output logic skip_out,
    output logic busy_out
);
    typedef struct packed {
        bbl_pkg::bbl_phase_e phase;
        logic [13:0] held;
        logic [7:0] wreg;
        logic [2:0] status;
        logic [6:0] pc_high_latch;
        bbl_pkg::bbl_file_wr_s file_wr;
        logic skip;
    } bbl_state_s;

    bbl_state_s state;
    bbl_state_s next_state;
    logic rst_n;
    logic [13:0] word;
    logic [5:0] op6;
    logic [3:0] op4;
    logic [6:0] faddr;
    logic [7:0] lit;
    logic [2:0] bit_idx;
    logic dest_file;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic alu_cin;
    bbl_pkg::bbl_alu_s alu;

    bbl_reset_sync u_reset_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .reset_n_out(rst_n)
    );

    // An indirect access stalls one cycle when its pointer reaches the upper region.
    function automatic logic needs_extra(input logic [6:0] addr, input logic [7:0] p0,
                                         input logic [7:0] p1);
        needs_extra = ((addr == `BBL_INDIRECT0_ADDR) && p0[7]) ||
                      ((addr == `BBL_INDIRECT1_ADDR) && p1[7]);
    endfunction

    // The word under execution is the held one while stalled, else the fresh fetch.
    assign word = (state.phase == bbl_pkg::BBL_EXTRA) ? state.held : fetch_in.word;
    assign op6 = word[13:8];
    assign op4 = word[13:10];
    assign faddr = word[`BBL_ADDR_MSB:0];
    assign dest_file = word[`BBL_DEST_BIT];
    assign bit_idx = word[9:7];
    assign lit = word[7:0];
    assign file_rd_addr_out = faddr;

    // Subtract forms feed the inverted subtrahend so carry means no borrow.
    always_comb begin
        alu_a = state.wreg;
        alu_b = file_rd_data_in;
        alu_cin = 1'b0;
        unique case (op6)
            `BBL_OP_ADD_CARRY: begin
                alu_cin = state.status[`BBL_FLAG_C];
            end
            `BBL_OP_SUB_BORROW: begin
                alu_a = file_rd_data_in;
                alu_b = ~state.wreg;
                alu_cin = state.status[`BBL_FLAG_C];
            end
            `BBL_OP_LIT_MINUS_W: begin
                alu_a = lit;
                alu_b = ~state.wreg;
                alu_cin = 1'b1;
            end
            default: begin
                alu_cin = 1'b0;
            end
        endcase
    end

    bbl_alu u_alu (
        .a_in(alu_a),
        .b_in(alu_b),
        .carry_in(alu_cin),
        .sum_out(alu)
    );

    always_comb begin
        logic [7:0] res;
        logic has_res;
        logic is_file_op;
        logic go;
        logic skip_now;
        res = 8'h00;
        has_res = 1'b0;
        is_file_op = 1'b0;
        skip_now = 1'b0;
        next_state = state;
        next_state.file_wr.wr = 1'b0;
        next_state.skip = 1'b0;
        go = 1'b0;
        unique case (state.phase)
            bbl_pkg::BBL_NOP: begin
                // Skipped word is fetched and discarded as a no-operation.
                if (fetch_in.valid) begin
                    next_state.phase = bbl_pkg::BBL_EXEC;
                end
            end
            bbl_pkg::BBL_EXTRA: begin
                go = 1'b1;
            end
            bbl_pkg::BBL_EXEC: begin
                if (fetch_in.valid) begin
                    // Literal forms carry no file address, so they never stall.
                    is_file_op = !(op6 inside {`BBL_OP_OR_LIT, `BBL_OP_XOR_LIT,
                                               `BBL_OP_LIT_MINUS_W, `BBL_OP_LOAD_PCH});
                    if (is_file_op && needs_extra(faddr, pointer0_high_in,
                                                  pointer1_high_in)) begin
                        next_state.phase = bbl_pkg::BBL_EXTRA;
                        next_state.held = fetch_in.word;
                    end else begin
                        go = 1'b1;
                    end
                end
            end
            default: begin
                next_state.phase = bbl_pkg::BBL_EXEC;
            end
        endcase

        if (go) begin
            next_state.phase = bbl_pkg::BBL_EXEC;
            unique case (op6)
                `BBL_OP_ADD_CARRY, `BBL_OP_SUB_BORROW: begin
                    res = alu.result;
                    has_res = 1'b1;
                    next_state.status = {alu.zero, alu.digit_carry, alu.carry};
                end
                `BBL_OP_ROT_LEFT: begin
                    res = {file_rd_data_in[6:0], state.status[`BBL_FLAG_C]};
                    has_res = 1'b1;
                    next_state.status[`BBL_FLAG_C] = file_rd_data_in[7];
                end
                `BBL_OP_ROT_RIGHT: begin
                    res = {state.status[`BBL_FLAG_C], file_rd_data_in[7:1]};
                    has_res = 1'b1;
                    next_state.status[`BBL_FLAG_C] = file_rd_data_in[0];
                end
                `BBL_OP_XOR_WF, `BBL_OP_OR_WF: begin
                    res = (op6 == `BBL_OP_XOR_WF) ? (state.wreg ^ file_rd_data_in)
                                                  : (state.wreg | file_rd_data_in);
                    has_res = 1'b1;
                    next_state.status[`BBL_FLAG_Z] = (res == 8'h00);
                end
                `BBL_OP_DEC_SKIP, `BBL_OP_INC_SKIP: begin
                    res = (op6 == `BBL_OP_DEC_SKIP) ? (file_rd_data_in - 8'h01)
                                                    : (file_rd_data_in + 8'h01);
                    has_res = 1'b1;
                    skip_now = (res == 8'h00);
                end
                `BBL_OP_OR_LIT, `BBL_OP_XOR_LIT: begin
                    next_state.wreg = (op6 == `BBL_OP_OR_LIT) ? (state.wreg | lit)
                                                              : (state.wreg ^ lit);
                    next_state.status[`BBL_FLAG_Z] = (next_state.wreg == 8'h00);
                end
                `BBL_OP_LIT_MINUS_W: begin
                    next_state.wreg = alu.result;
                    next_state.status = {alu.zero, alu.digit_carry, alu.carry};
                end
                `BBL_OP_LOAD_PCH: begin
                    if (word[7]) begin
                        next_state.pc_high_latch = word[6:0];
                    end
                end
                default: begin
                    if (op4 == `BBL_BIT_SKIP_CLEAR) begin
                        skip_now = !file_rd_data_in[bit_idx];
                    end else if (op4 == `BBL_BIT_SKIP_SET) begin
                        skip_now = file_rd_data_in[bit_idx];
                    end
                end
            endcase
            if (has_res) begin
                if (dest_file) begin
                    next_state.file_wr.wr = 1'b1;
                    next_state.file_wr.addr = faddr;
                    next_state.file_wr.data = res;
                end else begin
                    next_state.wreg = res;
                end
            end
            if (skip_now) begin
                next_state.phase = bbl_pkg::BBL_NOP;
                next_state.skip = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state.phase <= bbl_pkg::BBL_EXEC;
            state.held <= 14'h0000;
            state.wreg <= `BBL_WREG_RESET;
            state.status <= `BBL_STATUS_RESET;
            state.pc_high_latch <= `BBL_PCH_RESET;
            state.file_wr <= '0;
            state.skip <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // The fetch is held off while a stalled word finishes its extra cycle.
    assign fetch_ready_out = (state.phase != bbl_pkg::BBL_EXTRA);
    assign busy_out = (state.phase != bbl_pkg::BBL_EXEC);
    assign file_wr_out = state.file_wr;
    assign wreg_out = state.wreg;
    assign status_out = state.status;
    assign pc_high_latch_out = state.pc_high_latch;
    assign skip_out = state.skip;
endmodule
`default_nettype wire

//--- rtl/bbl_reset_sync.sv
// Two-stage synchroniser that releases the active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bbl_reset_sync (
    input wire logic clk_in,
    input wire logic reset_n_in,
    output logic reset_n_out
);
    logic [1:0] stage;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage <= 2'h0;
        end else begin
            stage <= {stage[0], 1'b1};
        end
    end

    assign reset_n_out = stage[1];
endmodule
`default_nettype wire

//--- test/bbl_decoder_assertions.sv
// Concurrent checks on the decoder ports.
`timescale 1ns/1ps
`default_nettype none
module bbl_decoder_chk (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire bbl_pkg::bbl_fetch_s fetch_in,
    input wire logic [7:0] file_rd_data_in,
    input wire logic [7:0] pointer0_high_in,
    input wire logic [7:0] pointer1_high_in,
    input wire logic fetch_ready_out,
    input wire logic [6:0] file_rd_addr_out,
    input wire bbl_pkg::bbl_file_wr_s file_wr_out,
    input wire logic [7:0] wreg_out,
    input wire logic [2:0] status_out,
    input wire logic [6:0] pc_high_latch_out,
    input wire logic skip_out,
    input wire logic busy_out
);
    logic [13:0] pw;
    logic [7:0] pf;
    logic [7:0] pr;
    logic [2:0] ps;
    wire logic [5:0] op = fetch_in.word[13:8];
    wire logic go = fetch_in.valid && fetch_ready_out && !busy_out;
    // Addresses 0 and 1 may stall, so single-cycle checks leave them out.
    wire logic take = go && fetch_in.word[6:1] != 6'h00;
    wire logic [7:0] b = pw[13] ? pw[7:0] : pf;
    wire logic [7:0] lres = pw[9] ? pr ^ b : pr | b;
    always_ff @(posedge clk_in) begin
        pw <= fetch_in.word;
        pf <= file_rd_data_in;
        pr <= wreg_out;
        ps <= status_out;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    a_add_carry: assert property (take && op == 6'h3d && !fetch_in.word[7] |=>
        {status_out[0], wreg_out} == {1'b0, pr} + {1'b0, pf} + {8'h00, ps[0]})
        else $error("add with carry wrong");
    a_sub_borrow: assert property (take && op == 6'h3b && !fetch_in.word[7] |=>
        {status_out[0], wreg_out} == {1'b0, pf} + {1'b0, ~pr} + {8'h00, ps[0]})
        else $error("subtract with borrow wrong");
    a_rotate_carry: assert property (take && op[5:1] == 5'h06 |=>
        status_out == {ps[2:1], pw[8] ? pf[7] : pf[0]}) else $error("rotate flags wrong");
    a_logic_zero: assert property (take && op inside {6'h04, 6'h06, 6'h38, 6'h3a} |=>
        status_out == {lres == 8'h00, ps[1:0]}) else $error("logic op flags wrong");
    a_step_skip: assert property (take && op inside {6'h0b, 6'h0f} |=>
        $stable(status_out) && skip_out == (pf == (pw[10] ? 8'hff : 8'h01)))
        else $error("step skip wrong");
    a_bit_skip: assert property (take && op[5:3] == 3'b011 |=>
        skip_out == (pf[pw[9:7]] == pw[10])) else $error("bit test skip wrong");
    a_skip_nop: assert property (skip_out |-> busy_out ##1 !file_wr_out.wr && !skip_out)
        else $error("skip cycle not a no-op");
    a_indirect_stall: assert property (go && op == 6'h06 && fetch_in.word[6:0] == 7'h00
        && pointer0_high_in[7] |=> busy_out && !fetch_ready_out && !file_wr_out.wr)
        else $error("indirect stall missing");
    a_borrow_stall: assert property (go && op == 6'h3b && fetch_in.word[6:0] == 7'h00
        && pointer0_high_in[7] |=> busy_out && !fetch_ready_out && !file_wr_out.wr)
        else $error("subtract with borrow stall missing");
    a_literal_single: assert property (go && op inside {6'h38, 6'h3a, 6'h3c, 6'h31} |=>
        !busy_out && fetch_ready_out) else $error("literal op took extra cycle");
    a_write_dest: assert property (take && op == 6'h06 |=> file_wr_out.wr == pw[7] &&
        (pw[7] ? file_wr_out.addr == pw[6:0] && file_wr_out.data == (pr ^ pf)
        : wreg_out == (pr ^ pf))) else $error("destination wrong");
    a_latch_load: assert property (take && op == 6'h31 && fetch_in.word[7] |=>
        pc_high_latch_out == pw[6:0] && $stable(status_out)) else $error("latch load wrong");
    a_lit_minus: assert property (take && op == 6'h3c |=>
        {status_out[0], wreg_out} == {1'b0, pw[7:0]} + {1'b0, ~pr} + 9'h001)
        else $error("literal minus wrong");
endmodule
bind bbl_decoder bbl_decoder_chk u_chk (.clk_in, .reset_n_in, .fetch_in, .file_rd_data_in,
    .pointer0_high_in, .pointer1_high_in, .fetch_ready_out, .file_rd_addr_out, .file_wr_out,
    .wreg_out, .status_out, .pc_high_latch_out, .skip_out, .busy_out);
`default_nettype wire

//--- test/bbl_file_model.sv
// File register space that answers the decoder's reads and takes its writes.
`timescale 1ns/1ps
`default_nettype none
module bbl_file_model (
    input wire logic clk_in,
    input wire logic [6:0] rd_addr_in,
    input wire bbl_pkg::bbl_file_wr_s wr_in,
    output logic [7:0] rd_data_out
);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    // A pending write is forwarded so the next instruction sees it, as in a real file.
    assign rd_data_out = (wr_in.wr && wr_in.addr == rd_addr_in) ? wr_in.data : mem[rd_addr_in];
    always @(posedge clk_in) if (wr_in.wr) mem[wr_in.addr] <= wr_in.data;
endmodule
`default_nettype wire

//--- test/test_byte_bit_literal_insn_decoder.sv
// Self-checking bench for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module test_byte_bit_literal_insn_decoder;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    bbl_pkg::bbl_fetch_s fetch_in = '0;
    logic [7:0] pointer0_high_in = 8'h00;
    logic [7:0] pointer1_high_in = 8'h00;
    logic [7:0] file_rd_data_in, wreg_out, w = 8'h00;
    logic [6:0] file_rd_addr_out, pc_high_latch_out, ph = 7'h00;
    logic [2:0] status_out, st = 3'h0;
    logic fetch_ready_out, skip_out, busy_out;
    bbl_pkg::bbl_file_wr_s file_wr_out;
    logic [7:0] mem [128];
    logic [16:0] q [$];
    logic [31:0] r = 32'h00011839;
    logic [5:0] ops [16] = '{6'h3d, 6'h3b, 6'h0d, 6'h0c, 6'h06, 6'h04, 6'h0b, 6'h0f,
        6'h38, 6'h3a, 6'h3c, 6'h31, 6'h18, 6'h1b, 6'h1c, 6'h1f};
    int miscompares = 0;
    int check_count = 0;
    always #25 clk_in = ~clk_in;
    bbl_decoder dut (.clk_in, .reset_n_in, .fetch_in, .file_rd_data_in, .pointer0_high_in,
        .pointer1_high_in, .fetch_ready_out, .file_rd_addr_out, .file_wr_out, .wreg_out,
        .status_out, .pc_high_latch_out, .skip_out, .busy_out);
    bbl_file_model fm (.clk_in, .rd_addr_in(file_rd_addr_out), .wr_in(file_wr_out),
        .rd_data_out(file_rd_data_in));
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [9:0] add(input logic [7:0] a, input logic [7:0] b, input logic c);
        logic [4:0] lo;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        return {lo[4], {1'b0, a} + {1'b0, b} + {8'h00, c}};
    endfunction
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic run(input logic [13:0] i, input logic [15:0] p);
        logic [7:0] f;
        logic [7:0] res;
        logic [9:0] a;
        logic [2:0] s;
        logic sk;
        logic lit;
        logic wrf;
        f = mem[i[6:0]];
        s = st;
        sk = 1'b0;
        res = f;
        lit = i[13:8] inside {6'h3c, 6'h3a, 6'h38};
        case (i[13:8])
            6'h3d, 6'h3b, 6'h3c: begin
                a = i[13:8] == 6'h3d ? add(w, f, st[0]) : i[8] ? add(f, ~w, st[0])
                    : add(i[7:0], ~w, 1'b1);
                res = a[7:0];
                s = {res == 8'h00, a[9:8]};
            end
            6'h0d, 6'h0c: begin
                res = i[8] ? {f[6:0], st[0]} : {st[0], f[7:1]};
                s[0] = i[8] ? f[7] : f[0];
            end
            6'h06, 6'h04, 6'h3a, 6'h38: begin
                res = i[9] ? w ^ (i[13] ? i[7:0] : f) : w | (i[13] ? i[7:0] : f);
                s[2] = res == 8'h00;
            end
            6'h0b, 6'h0f: begin
                res = i[10] ? f + 8'h01 : f - 8'h01;
                sk = res == 8'h00;
            end
            6'h31: if (i[7]) ph = i[6:0];
            default: sk = f[i[9:7]] == i[10];
        endcase
        wrf = !lit && i[13:8] != 6'h31 && i[13:11] != 3'b011 && i[7];
        if (lit || (!i[7] && i[13:8] != 6'h31 && i[13:11] != 3'b011)) w = res;
        if (wrf) mem[i[6:0]] = res;
        st = s;
        if (sk || wrf) q.push_back({sk, wrf, wrf ? {i[6:0], res} : 15'h0000});
        fetch_in <= {1'b1, i};
        {pointer0_high_in, pointer1_high_in} <= p;
        do @(posedge clk_in); while (!(fetch_ready_out && !busy_out));
        // The word offered in the skip's no-op cycle must be thrown away.
        if (sk) begin
            fetch_in <= {1'b1, 14'h3aff};
            do @(posedge clk_in); while (!fetch_ready_out);
        end
    endtask
    task automatic done(input string msg);
        fetch_in <= '0;
        repeat (4) @(posedge clk_in);
        check({wreg_out, status_out, pc_high_latch_out}, {w, st, ph});
        $display("%s done", msg);
    endtask
    always @(negedge clk_in) begin
        if (file_wr_out.wr || skip_out) begin
            check({skip_out, file_wr_out.wr, file_wr_out.wr ? {file_wr_out.addr,
                file_wr_out.data} : 15'h0000}, q.size() > 0 ? q.pop_front() : 17'h10001);
        end
    end
    initial begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        run({6'h3a, w}, 16'h0000);
        run({6'h3a, mem[5] ^ 8'h01}, 16'h0000);
        run(14'h0685, 16'h0000);
        run(14'h0b85, 16'h0000);
        run({6'h3a, w ^ 8'hff}, 16'h0000);
        run(14'h0485, 16'h0000);
        run(14'h0f05, 16'h0000);
        run(14'h0600, 16'h8000);
        run(14'h1c81, 16'h0080);
        run(14'h0680, 16'h8000);
        done("directed");
        for (int n = 0; n < 300; n++) begin
            r = nxt(r);
            run({ops[r[3:0]], r[15:8]}, r[31:16]);
        end
        done("random");
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        miscompares++;
        finish_test;
    end
endmodule
`default_nettype wire
